// [eeprom_i2c_read_sequencer_tb.sv]
// Self-checking bench: host end and memory end joined over the two-wire link.
`timescale 1ns/1ps
`default_nettype none
module eeprom_i2c_read_sequencer_tb;
	localparam int AW = 9;
	localparam logic [2:0] PINS = 3'h5;
	localparam logic [2:0] SEL_MASK = 3'h7 << (AW - 8);
	logic core_clk, rstn, cmd_valid, cmd_ready, cmd_random, rd_valid, rd_last, done, nack_err, load_en;
	logic scl_d, sda_d;
	logic [2:0] cmd_ext;
	logic [3:0] nbit;
	logic [7:0] cmd_addr, cmd_count, rd_data, load_data, wire_byte, sh;
	logic [AW-1:0] load_addr, ptr;
	logic [7:0] mem [0:(1<<AW)-1];
	logic [31:0] seed;
	int err_total, checked, i;

	ers_link_if link_bus();
	ers_device #(.ADDR_W(AW)) ers_device_inst (.core_clk(core_clk), .rstn(rstn), .device_select_pins(PINS),
		.load_en(load_en), .load_addr(load_addr), .load_data(load_data), .link(link_bus));
	ers_host #(.QUARTER_CYC(8)) ers_host_inst (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_random(cmd_random), .cmd_ext(cmd_ext), .cmd_addr(cmd_addr),
		.cmd_count(cmd_count), .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last), .done(done),
		.nack_err(nack_err), .link(link_bus));
	ers_props #(.ADDR_W(AW), .SEL(PINS)) ers_props_inst (.core_clk(core_clk), .rstn(rstn),
		.m_sda_o(link_bus.m_sda_o), .m_sda_oe(link_bus.m_sda_oe), .s_sda_o(link_bus.s_sda_o),
		.s_sda_oe(link_bus.s_sda_oe), .scl(link_bus.scl), .sda(link_bus.sda));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	function automatic logic sel_ok(input logic [2:0] ext);
		return ((ext ^ PINS) & SEL_MASK) == 3'h0;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Captures the first byte after each START, shifted in MSB first
	always @(posedge core_clk) begin
		scl_d <= link_bus.scl;
		sda_d <= link_bus.sda;
		if (link_bus.scl && scl_d && sda_d && !link_bus.sda) begin
			nbit <= 4'h0;
		end else if (link_bus.scl && !scl_d) begin
			sh <= {sh[6:0], link_bus.sda};
			if (nbit == 4'h7) wire_byte <= {sh[6:0], link_bus.sda};
			if (nbit != 4'hF) nbit <= nbit + 4'h1;
		end
	end

	task automatic rd_cmd(input logic rnd, input logic [2:0] ext, input logic [7:0] addr, input logic [7:0] cnt);
		logic ok;
		logic [7:0] n, ce;
		int k;
		ok = sel_ok(ext);
		ce = (cnt == 8'h00) ? 8'h01 : cnt;
		n = 8'h00;
		if (rnd && ok) ptr = AW'({ext, addr});
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_random = rnd;
		cmd_ext = ext;
		cmd_addr = addr;
		cmd_count = cnt;
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b0;
		chk(cmd_ready, 1'b0, "busy after accept");
		cmd_addr = seed[15:8];
		for (k = 0; k < 20000 && done !== 1'b1; k++) begin
			@(posedge core_clk);
			#1;
			if (rd_valid === 1'b1) begin
				chk(rd_data, mem[ptr], "read data");
				chk(rd_last, (n + 8'h01) == ce, "last flag");
				ptr = ptr + 1'b1;
				n = n + 8'h01;
			end
		end
		if (k >= 20000) begin
			err_total++;
			finish_test();
		end
		chk(n, ok ? ce : 8'h00, "byte count");
		chk(nack_err, !ok, "address refusal");
		chk(wire_byte, {4'hA, ext, !rnd || ok}, "address byte on wire");
		chk({link_bus.scl, link_bus.sda}, 2'b11, "idle lines");
		chk(cmd_ready, 1'b1, "ready with done");
		$display("test done: random %0d ext %h addr %h count %0d", rnd, ext, addr, cnt);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		rstn = 1'b0;
		{cmd_valid, cmd_random, load_en} = 3'h0;
		cmd_ext = 3'h0;
		{cmd_addr, cmd_count, load_data} = 24'h000000;
		load_addr = '0;
		ptr = '0;
		{scl_d, sda_d, nbit} = 6'h3F;
		seed = 32'hCBD0;
		err_total = 0;
		checked = 0;
		repeat (2) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		for (i = 0; i < (1 << AW); i++) begin
			seed = xs(seed);
			load_en = 1'b1;
			load_addr = AW'(i);
			load_data = seed[7:0];
			mem[i] = seed[7:0];
			@(posedge core_clk);
			#1;
		end
		load_en = 1'b0;
		rd_cmd(1'b1, {PINS[2:1], 1'b0}, 8'h0E, 8'h04);
		rd_cmd(1'b1, {PINS[2:1], 1'b1}, 8'hFE, 8'h04);
		rd_cmd(1'b0, {PINS[2:1], 1'b0}, 8'h55, 8'h02);
		rd_cmd(1'b1, {~PINS[2:1], 1'b0}, 8'h10, 8'h01);
		rd_cmd(1'b0, {PINS[2:1], 1'b1}, 8'h20, 8'h01);
		rd_cmd(1'b1, {PINS[2:1], 1'b1}, 8'h33, 8'h00);
		for (i = 0; i < 10; i++) begin
			seed = xs(seed);
			rd_cmd(seed[8], {PINS[2] ^ (seed[12] & seed[13]), PINS[1], seed[9]}, seed[7:0],
				{6'h00, seed[11:10]} + 8'h01);
		end
		finish_test();
	end
endmodule
`default_nettype wire

// [ers_device.sv]
// Serial memory end of the link: address decode, byte pointer and read streaming on SCL.
`timescale 1ns/1ps
`default_nettype none
module ers_device #(
	parameter int ADDR_W = ers_pkg::ADDR_W_DEF
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [2:0] device_select_pins,
	input wire logic load_en,
	input wire logic [ADDR_W-1:0] load_addr,
	input wire logic [7:0] load_data,
	ers_link_if.device link
);
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int DEPTH = 1 << ADDR_W;
	localparam int UPPER_W = ADDR_W - ers_pkg::BYTE_BITS;
	// Extension bits above the upper array address bits are compared with the pins
	localparam logic [2:0] SEL_MASK = ers_pkg::EXT_ALL << UPPER_W;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0] mem [0:DEPTH-1];

	logic start_tog_reg;
	logic start_tog_next;

	ers_pkg::ers_dev_state_type state_reg;
	ers_pkg::ers_dev_state_type state_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [2:0] ext_reg;
	logic [2:0] ext_next;
	logic [ADDR_W-1:0] ptr_reg;
	logic [ADDR_W-1:0] ptr_next;
	logic [7:0] tx_reg;
	logic [7:0] tx_next;
	logic start_seen_reg;
	logic start_seen_next;

	logic sda_oe_reg;
	logic sda_oe_next;
	logic sda_o_reg;

	logic start_new;
	logic [7:0] byte_in;
	logic addr_match;

	// ------------------------------------------------------------
	// Backdoor load port
	// ------------------------------------------------------------
	// Dual-port array: written from core_clk, read from SCL.
	// Loading while a read is in flight may return a torn byte.
	always_ff @(posedge core_clk) begin
		if (load_en) begin
			mem[load_addr] <= load_data;
		end
	end

	// ------------------------------------------------------------
	// START detection
	// ------------------------------------------------------------
	// SDA falling while SCL is high; SCL has no edge to see this,
	// so SDA itself clocks one toggle flag.
	always_comb begin
		start_tog_next = start_tog_reg;
		if (link.scl) begin
			start_tog_next = ~start_tog_reg;
		end
	end

	always_ff @(negedge link.sda or negedge rstn) begin
		if (!rstn) begin
			start_tog_reg <= 1'b0;
		end else begin
			start_tog_reg <= start_tog_next;
		end
	end

	// ------------------------------------------------------------
	// Receive and sequence on rising SCL
	// ------------------------------------------------------------
	assign start_new = start_tog_reg != start_seen_reg;
	assign byte_in = {shift_reg[6:0], link.sda};
	assign addr_match = (byte_in[ers_pkg::TYPE_HI:ers_pkg::TYPE_LO] == ers_pkg::DEV_TYPE_CODE) &&
		(((byte_in[ers_pkg::EXT_HI:ers_pkg::EXT_LO] ^ device_select_pins) & SEL_MASK) == 3'h0);

	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		ext_next = ext_reg;
		ptr_next = ptr_reg;
		tx_next = tx_reg;
		start_seen_next = start_seen_reg;
		if (start_new) begin
			// First rising edge after a START carries address bit 7
			start_seen_next = start_tog_reg;
			state_next = ers_pkg::DEV_ADDR;
			shift_next = byte_in;
			bit_cnt_next = 4'h1;
		end else begin
			unique case (state_reg)
				ers_pkg::DEV_IDLE, ers_pkg::DEV_WAIT: begin
				end
				ers_pkg::DEV_ADDR: begin
					shift_next = byte_in;
					bit_cnt_next = bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == ers_pkg::LAST_BIT) begin
						if (addr_match) begin
							ext_next = byte_in[ers_pkg::EXT_HI:ers_pkg::EXT_LO];
							state_next = ers_pkg::DEV_ACK_ADDR;
						end else begin
							state_next = ers_pkg::DEV_IDLE;
						end
					end
				end
				ers_pkg::DEV_ACK_ADDR: begin
					bit_cnt_next = 4'h0;
					if (shift_reg[ers_pkg::RW_POS] == ers_pkg::RW_READ) begin
						// Current pointer is whatever the last access left behind
						state_next = ers_pkg::DEV_SEND;
						tx_next = mem[ptr_reg];
						ptr_next = ADDR_W'(ptr_reg + 1'b1);
					end else begin
						state_next = ers_pkg::DEV_WORD;
					end
				end
				ers_pkg::DEV_WORD: begin
					shift_next = byte_in;
					bit_cnt_next = bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == ers_pkg::LAST_BIT) begin
						// Truncation keeps only the low extension bits as upper address
						ptr_next = ADDR_W'({ext_reg, byte_in});
						state_next = ers_pkg::DEV_ACK_WORD;
					end
				end
				ers_pkg::DEV_ACK_WORD: begin
					// Write data is not supported; wait for a repeated START
					state_next = ers_pkg::DEV_WAIT;
				end
				ers_pkg::DEV_SEND: begin
					bit_cnt_next = bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == ers_pkg::LAST_BIT) begin
						state_next = ers_pkg::DEV_MACK;
					end
				end
				ers_pkg::DEV_MACK: begin
					bit_cnt_next = 4'h0;
					if (!link.sda) begin
						state_next = ers_pkg::DEV_SEND;
						tx_next = mem[ptr_reg];
						// Natural binary wrap spans pages and ends at the array top
						ptr_next = ADDR_W'(ptr_reg + 1'b1);
					end else begin
						state_next = ers_pkg::DEV_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge link.scl or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ers_pkg::DEV_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			ext_reg <= 3'h0;
			ptr_reg <= '0;
			tx_reg <= 8'hFF;
			start_seen_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			ext_reg <= ext_next;
			ptr_reg <= ptr_next;
			tx_reg <= tx_next;
			start_seen_reg <= start_seen_next;
		end
	end

	// ------------------------------------------------------------
	// Drive on falling SCL
	// ------------------------------------------------------------
	// Open drain: only ever pulls low. Master ACK slot is left released.
	always_comb begin
		sda_oe_next = 1'b0;
		unique case (state_reg)
			ers_pkg::DEV_ACK_ADDR, ers_pkg::DEV_ACK_WORD: begin
				sda_oe_next = 1'b1;
			end
			ers_pkg::DEV_SEND: begin
				sda_oe_next = ~tx_reg[ers_pkg::MSB_IDX - bit_cnt_reg[2:0]];
			end
			ers_pkg::DEV_IDLE, ers_pkg::DEV_ADDR, ers_pkg::DEV_WORD,
			ers_pkg::DEV_WAIT, ers_pkg::DEV_MACK: begin
				sda_oe_next = 1'b0;
			end
		endcase
	end

	always_ff @(negedge link.scl or negedge rstn) begin
		if (!rstn) begin
			sda_oe_reg <= 1'b0;
			sda_o_reg <= 1'b0;
		end else begin
			sda_oe_reg <= sda_oe_next;
			sda_o_reg <= 1'b0;
		end
	end

	assign link.s_sda_oe = sda_oe_reg;
	assign link.s_sda_o = sda_o_reg;
endmodule
`default_nettype wire

// [ers_host.sv]
// Bus master end: builds SCL from core_clk and runs current and random reads.
`timescale 1ns/1ps
`default_nettype none
module ers_host #(
	parameter int QUARTER_CYC = ers_pkg::QUARTER_CYC
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_random,
	input wire logic [2:0] cmd_ext,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_count,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic rd_last,
	output logic done,
	output logic nack_err,
	ers_link_if.host link
);
	localparam int TW = $clog2(QUARTER_CYC + 1);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	ers_pkg::ers_host_state_type seq_reg, seq_next;
	logic [TW-1:0] tick_reg, tick_next;
	logic [1:0] ph_reg, ph_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] byte_reg, byte_next;
	logic [7:0] rx_reg, rx_next;
	logic [7:0] left_reg, left_next;
	logic random_reg, random_next;
	logic [2:0] ext_reg, ext_next;
	logic [7:0] addr_reg, addr_next;
	logic scl_oe_reg, scl_oe_next;
	logic sda_oe_reg, sda_oe_next;
	logic ready_reg, ready_next;
	logic rdv_reg, rdv_next;
	logic [7:0] rdd_reg, rdd_next;
	logic rdl_reg, rdl_next;
	logic done_reg, done_next;
	logic nack_reg, nack_next;
	logic sda_s;
	logic tick;
	logic sym_end;
	logic bit_val;
	logic more;

	ers_sync3 #(.RESET_VAL(1'b1)) u_sda_sync (
		.clk(core_clk),
		.rstn(rstn),
		.async_in(link.sda),
		.level(sda_s)
	);

	assign tick = tick_reg == TW'(QUARTER_CYC - 1);
	assign sym_end = tick && (ph_reg == ers_pkg::PH_LAST);
	assign more = left_reg != 8'h01;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		seq_next = seq_reg;
		tick_next = tick ? '0 : TW'(tick_reg + 1'b1);
		ph_next = tick ? ph_reg + 2'h1 : ph_reg;
		bit_next = bit_reg;
		byte_next = byte_reg;
		rx_next = rx_reg;
		left_next = left_reg;
		random_next = random_reg;
		ext_next = ext_reg;
		addr_next = addr_reg;
		ready_next = ready_reg;
		rdv_next = 1'b0;
		rdd_next = rdd_reg;
		rdl_next = rdl_reg;
		done_next = 1'b0;
		nack_next = nack_reg;
		unique case (seq_reg)
			ers_pkg::HST_IDLE: begin
				tick_next = '0;
				ph_next = 2'h0;
				if (cmd_valid && ready_reg) begin
					seq_next = ers_pkg::HST_START1;
					ready_next = 1'b0;
					nack_next = 1'b0;
					random_next = cmd_random;
					ext_next = cmd_ext;
					addr_next = cmd_addr;
					left_next = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
					// Random read begins as a dummy write
					byte_next = {ers_pkg::DEV_TYPE_CODE, cmd_ext,
						cmd_random ? ers_pkg::RW_WRITE : ers_pkg::RW_READ};
				end
			end
			ers_pkg::HST_START1: begin
				if (sym_end) begin
					seq_next = random_reg ? ers_pkg::HST_DEVW : ers_pkg::HST_DEVR;
					bit_next = 4'h0;
				end
			end
			ers_pkg::HST_START2: begin
				if (sym_end) begin
					seq_next = ers_pkg::HST_DEVR;
					bit_next = 4'h0;
				end
			end
			ers_pkg::HST_DEVW, ers_pkg::HST_WORD, ers_pkg::HST_DEVR, ers_pkg::HST_READ: begin
				if (sym_end && bit_reg != ers_pkg::ACK_SLOT) begin
					bit_next = bit_reg + 4'h1;
					rx_next = {rx_reg[6:0], sda_s};
				end else if (sym_end) begin
					bit_next = 4'h0;
					if (seq_reg == ers_pkg::HST_READ) begin
						rdv_next = 1'b1;
						rdd_next = rx_reg;
						rdl_next = ~more;
						left_next = left_reg - 8'h01;
						seq_next = more ? ers_pkg::HST_READ : ers_pkg::HST_STOP;
					end else if (sda_s) begin
						nack_next = 1'b1;
						seq_next = ers_pkg::HST_STOP;
					end else if (seq_reg == ers_pkg::HST_DEVW) begin
						seq_next = ers_pkg::HST_WORD;
						byte_next = addr_reg;
					end else if (seq_reg == ers_pkg::HST_WORD) begin
						seq_next = ers_pkg::HST_START2;
						byte_next = {ers_pkg::DEV_TYPE_CODE, ext_reg, ers_pkg::RW_READ};
					end else begin
						seq_next = ers_pkg::HST_READ;
					end
				end
			end
			ers_pkg::HST_STOP: begin
				if (sym_end) begin
					seq_next = ers_pkg::HST_IDLE;
					ready_next = 1'b1;
					done_next = 1'b1;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Line drive
	// ------------------------------------------------------------
	// Data bits move SDA only in phase 1, with SCL already low; START and STOP move it in phase 3, with SCL high.
	always_comb begin
		bit_val = 1'b1;
		if (bit_reg != ers_pkg::ACK_SLOT) begin
			if (seq_reg != ers_pkg::HST_READ) begin
				bit_val = byte_reg[ers_pkg::MSB_IDX - bit_reg[2:0]];
			end
		end else if (seq_reg == ers_pkg::HST_READ) begin
			bit_val = ~more;
		end
		scl_oe_next = (ph_reg == 2'h0) || (ph_reg == 2'h1);
		sda_oe_next = sda_oe_reg;
		unique case (seq_reg)
			ers_pkg::HST_IDLE: begin
				scl_oe_next = 1'b0;
				sda_oe_next = 1'b0;
			end
			ers_pkg::HST_START1, ers_pkg::HST_START2: begin
				if (ph_reg == 2'h1) begin
					sda_oe_next = 1'b0;
				end else if (ph_reg == ers_pkg::PH_LAST) begin
					sda_oe_next = 1'b1;
				end
			end
			ers_pkg::HST_STOP: begin
				if (ph_reg == 2'h1) begin
					sda_oe_next = 1'b1;
				end else if (ph_reg == ers_pkg::PH_LAST) begin
					sda_oe_next = 1'b0;
				end
			end
			ers_pkg::HST_DEVW, ers_pkg::HST_WORD, ers_pkg::HST_DEVR, ers_pkg::HST_READ: begin
				if (ph_reg == 2'h1) begin
					sda_oe_next = ~bit_val;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			seq_reg <= ers_pkg::HST_IDLE;
			tick_reg <= '0;
			ph_reg <= 2'h0;
			bit_reg <= 4'h0;
			byte_reg <= 8'h00;
			rx_reg <= 8'h00;
			left_reg <= 8'h00;
			random_reg <= 1'b0;
			ext_reg <= 3'h0;
			addr_reg <= 8'h00;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			ready_reg <= 1'b1;
			rdv_reg <= 1'b0;
			rdd_reg <= 8'h00;
			rdl_reg <= 1'b0;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			seq_reg <= seq_next;
			tick_reg <= tick_next;
			ph_reg <= ph_next;
			bit_reg <= bit_next;
			byte_reg <= byte_next;
			rx_reg <= rx_next;
			left_reg <= left_next;
			random_reg <= random_next;
			ext_reg <= ext_next;
			addr_reg <= addr_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			ready_reg <= ready_next;
			rdv_reg <= rdv_next;
			rdd_reg <= rdd_next;
			rdl_reg <= rdl_next;
			done_reg <= done_next;
			nack_reg <= nack_next;
		end
	end

	assign link.m_scl_oe = scl_oe_reg;
	assign link.m_scl_o = 1'b0;
	assign link.m_sda_oe = sda_oe_reg;
	assign link.m_sda_o = 1'b0;
	assign cmd_ready = ready_reg;
	assign rd_valid = rdv_reg;
	assign rd_data = rdd_reg;
	assign rd_last = rdl_reg;
	assign done = done_reg;
	assign nack_err = nack_reg;
endmodule
`default_nettype wire

// [ers_link_if.sv]
// Two-wire link between the bus master and the serial memory.
`timescale 1ns/1ps
`default_nettype none
interface ers_link_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-ups: a released line reads high
	assign scl = m_scl_oe ? m_scl_o : 1'b1;
	assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

	modport host (
		output m_scl_o,
		output m_scl_oe,
		output m_sda_o,
		output m_sda_oe,
		input scl,
		input sda
	);

	modport device (
		output s_sda_o,
		output s_sda_oe,
		input scl,
		input sda
	);
endinterface
`default_nettype wire

// [ers_pkg.sv]
// Shared constants and state types for the serial memory read sequencer.
// Functional notes
// - Random read opens with dummy address write.
// - After address ACK, master repeats START with read.
// - Device acknowledges read address, sends addressed byte.
// - Single byte read ends with NoACK then STOP.
// - Master ACK makes device send next consecutive byte.
// - NoACK plus STOP ends reading; device releases bus.
// - Address counter wraps only at end of array.
// - Address byte is 1010, extension bits, read/write.
// - Extension bits: select compare, rest upper address.
// - Device ACKs low on ninth clock; read releases.
// - Plain read request continues from current counter.
package ers_pkg;

	// ------------------------------------------------------------
	// Address byte layout
	// ------------------------------------------------------------
	localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
	localparam int TYPE_HI = 7;
	localparam int TYPE_LO = 4;
	localparam int EXT_HI = 3;
	localparam int EXT_LO = 1;
	localparam int RW_POS = 0;
	localparam logic [2:0] EXT_ALL = 3'h7;
	localparam logic RW_READ = 1'b1;
	localparam logic RW_WRITE = 1'b0;

	// ------------------------------------------------------------
	// Sizes and bit counting
	// ------------------------------------------------------------
	localparam int BYTE_BITS = 8;
	localparam int ADDR_W_DEF = 9;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [2:0] MSB_IDX = 3'h7;
	localparam logic [1:0] PH_LAST = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CORE_CLK_NS = 40;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CORE_CLK_NS);

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DEV_IDLE = 3'h0,
		DEV_ADDR = 3'h1,
		DEV_ACK_ADDR = 3'h3,
		DEV_SEND = 3'h2,
		DEV_MACK = 3'h6,
		DEV_WORD = 3'h7,
		DEV_ACK_WORD = 3'h5,
		DEV_WAIT = 3'h4
	} ers_dev_state_type;

	typedef enum logic [2:0] {
		HST_IDLE = 3'h0,
		HST_START1 = 3'h1,
		HST_DEVW = 3'h3,
		HST_WORD = 3'h2,
		HST_START2 = 3'h6,
		HST_DEVR = 3'h7,
		HST_READ = 3'h5,
		HST_STOP = 3'h4
	} ers_host_state_type;

endpackage

// [ers_props.sv]
// Concurrent checks on the two-wire link between the host end and the memory end.
`timescale 1ns/1ps
`default_nettype none
module ers_props #(
	parameter int ADDR_W = 9,
	parameter logic [2:0] SEL = 3'h0
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// Extension bits used as upper address are not compared with the select pins
	localparam logic [2:0] SEL_MASK = 3'h7 << (ADDR_W - 8);
	logic scl_reg, sda_reg, frame_reg, frame_next, rd_reg, rd_next, rel_reg, rel_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [1:0] byte_reg, byte_next;
	logic [7:0] sh_reg, sh_next;
	logic start_ev, stop_ev, rise_ev, ninth_ev, addr_ok;

	// ------------------------------------------------------------
	// Frame tracker
	// ------------------------------------------------------------
	assign start_ev = scl && scl_reg && sda_reg && !sda;
	assign stop_ev = scl && scl_reg && !sda_reg && sda;
	assign rise_ev = scl && !scl_reg;
	assign ninth_ev = rise_ev && cnt_reg == 4'h8;
	assign addr_ok = sh_reg[7:4] == 4'hA && ((sh_reg[3:1] ^ SEL) & SEL_MASK) == 3'h0;

	always_comb begin
		frame_next = start_ev ? 1'b1 : (stop_ev ? 1'b0 : frame_reg);
		cnt_next = cnt_reg;
		byte_next = byte_reg;
		sh_next = sh_reg;
		rd_next = rd_reg;
		rel_next = rel_reg;
		if (rise_ev) begin
			sh_next = {sh_reg[6:0], sda};
			cnt_next = ninth_ev ? 4'h0 : cnt_reg + 4'h1;
		end
		if (ninth_ev && byte_reg != 2'h3) begin
			byte_next = byte_reg + 2'h1;
		end
		if (ninth_ev && byte_reg == 2'h0 && sh_reg[0] && !sda) begin
			rd_next = 1'b1;
		end
		// A read byte left unacknowledged ends the session
		if (ninth_ev && rd_reg && byte_reg != 2'h0 && sda) begin
			rel_next = 1'b1;
		end
		if (start_ev) begin
			cnt_next = 4'h0;
			byte_next = 2'h0;
			rd_next = 1'b0;
			rel_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			frame_reg <= 1'b0;
			rd_reg <= 1'b0;
			rel_reg <= 1'b0;
			cnt_reg <= 4'h0;
			byte_reg <= 2'h0;
			sh_reg <= 8'h00;
		end else begin
			scl_reg <= scl;
			sda_reg <= sda;
			frame_reg <= frame_next;
			rd_reg <= rd_next;
			rel_reg <= rel_next;
			cnt_reg <= cnt_next;
			byte_reg <= byte_next;
			sh_reg <= sh_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_open_drain: assert property (!(m_sda_oe && m_sda_o) && !(s_sda_oe && s_sda_o))
		else $error("a line was driven high");
	a_addr_quiet: assert property (byte_reg == 2'h0 && cnt_reg < 4'h8 |-> !s_sda_oe)
		else $error("device drove during address bits");
	a_addr_ack: assert property (ninth_ev && byte_reg == 2'h0 && addr_ok |-> s_sda_oe)
		else $error("matching address not acknowledged");
	a_addr_refuse: assert property (ninth_ev && byte_reg == 2'h0 && !addr_ok |-> !s_sda_oe)
		else $error("foreign address acknowledged");
	a_read_release: assert property (ninth_ev && rd_reg && byte_reg != 2'h0 |-> !s_sda_oe)
		else $error("device held data line in master ack slot");
	a_nack_release: assert property (rel_reg |-> !s_sda_oe)
		else $error("device drove after master noack");
	a_idle_quiet: assert property (!frame_reg |-> !s_sda_oe)
		else $error("device drove outside a frame");
	a_dev_stable: assert property (scl && scl_reg |-> $stable(s_sda_oe))
		else $error("device changed data while clock high");
	// The START and STOP symbols each carry one SCL rise, so only the condition itself may move SDA
	a_host_stable: assert property (scl && scl_reg && $changed(m_sda_oe) |-> start_ev || stop_ev)
		else $error("host data edge with clock high inside a byte");
	// The STOP after a noack pulls SDA low with the bit counter at zero and keeps it low after the counter reads one
	a_host_listen: assert property (rd_reg && !rel_reg && byte_reg != 2'h0 && cnt_reg >= 4'h1 && cnt_reg <= 4'h7
		|-> !m_sda_oe)
		else $error("host drove during read data bits");

	c_read_ack: cover property (ninth_ev && byte_reg == 2'h0 && sh_reg[0] && s_sda_oe);
	c_seq_ack: cover property (ninth_ev && rd_reg && byte_reg != 2'h0 && !sda);
	c_refused: cover property (ninth_ev && byte_reg == 2'h0 && !addr_ok);
endmodule
`default_nettype wire

// [ers_sync3.sv]
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ers_sync3 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic async_in,
	output logic level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	logic level_next;

	always_comb begin
		level_next = level_reg;
		if (s2_reg == s3_reg) begin
			level_next = s3_reg;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
			level_reg <= RESET_VAL;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
endmodule
`default_nettype wire
